// File: sppcr_pkg.sv
package sppcr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] SYNC_BUFFER_POWER_DOWN_ADDR  = 12'h0203;
    localparam logic [11:0] RECOVERY_LOGIC_RESET_ADDR    = 12'h0206;
    localparam logic [11:0] RECOVERY_OPERATING_MODE_ADDR = 12'h0230;
    localparam logic [11:0] LINK_CONFIG_BYTE_ADDR        = 12'h0232;
    localparam logic [11:0] EQUALIZER_BIAS_ADDR          = 12'h0268;
    localparam logic [11:0] LINK_PLL_ENABLE_CONTROL_ADDR = 12'h0280;
    localparam logic [11:0] LINK_PLL_STATUS_ADDR         = 12'h0281;
    localparam logic [11:0] LINK_PLL_FILTER_TRIM_A_ADDR  = 12'h0284;
    localparam logic [11:0] LINK_PLL_FILTER_TRIM_B_ADDR  = 12'h0285;
    localparam logic [11:0] LINK_PLL_FILTER_TRIM_C_ADDR  = 12'h0286;
    localparam logic [11:0] LINK_PLL_PUMP_TRIM_ADDR      = 12'h0287;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FIRST_SYNC_BIT    = 1;
    localparam int SECOND_SYNC_BIT   = 0;
    localparam int RECOVERY_RST_BIT  = 0;
    localparam int HALF_RATE_BIT     = 5;
    localparam int OVERSAMPLE_BIT    = 1;
    localparam int MODE_RSVD_LSB     = 2;
    localparam int EQ_SELECT_LSB     = 6;
    localparam int PLL_RECAL_BIT     = 2;
    localparam int PLL_ON_BIT        = 0;
    localparam int BAND_HIGH_BIT     = 5;
    localparam int BAND_LOW_BIT      = 4;
    localparam int CALIBRATED_BIT    = 3;
    localparam int LOCKED_BIT        = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        SYNC_OFF_RESET     = 1'b0;
    localparam logic        RECOVERY_RST_RESET = 1'b1;
    localparam logic        HALF_RATE_RESET    = 1'b1;
    localparam logic [2:0]  MODE_RSVD_RESET    = 3'h2;
    localparam logic        OVERSAMPLE_RESET   = 1'b0;
    localparam logic [7:0]  LINK_CONFIG_RESET  = 8'h00;
    localparam logic [1:0]  EQ_SELECT_RESET    = 2'h1;
    localparam logic [5:0]  EQ_RSVD_RESET      = 6'h22;
    localparam logic [7:0]  FILTER_A_RESET     = 8'h77;
    localparam logic [7:0]  FILTER_B_RESET     = 8'h87;
    localparam logic [7:0]  FILTER_C_RESET     = 8'h08;
    localparam logic [7:0]  PUMP_RESET         = 8'h3F;
    localparam logic [7:0]  READ_IDLE          = 8'h00;
    localparam logic        PLL_ON_RESET       = 1'b0;
    localparam logic        PLL_RECAL_RESET    = 1'b0;
    localparam logic        CAL_START_RESET    = 1'b0;
    localparam logic [3:0]  STATUS_RESET       = 4'h0;

endpackage

// File: sppcr_regs.sv
module sppcr_regs
    import sppcr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        pllLockedIn,
    input  wire logic        pllCalibratedIn,
    input  wire logic        pllBandHighIn,
    input  wire logic        pllBandLowIn,
    output logic      [7:0]  regReadData,
    output logic             firstSyncBufferOff,
    output logic             secondSyncBufferOff,
    output logic             recoveryReset_n,
    output logic             halfRateRecoveryOn,
    output logic             inputOversampleOn,
    output logic      [2:0]  recoveryModeReserved,
    output logic      [7:0]  linkConfigByte,
    output logic      [1:0]  equalizerPowerSelect,
    output logic      [5:0]  equalizerReserved,
    output logic             linkPllOn,
    output logic             linkPllCalStart,
    output logic      [7:0]  linkPllFilterTrimA,
    output logic      [7:0]  linkPllFilterTrimB,
    output logic      [7:0]  linkPllFilterTrimC,
    output logic      [7:0]  linkPllPumpTrim
);

    // ------------------------------------------------------------
    // Status input synchronisers
    // ------------------------------------------------------------
    logic [3:0] statusMeta;
    logic [3:0] statusSync;
    logic       linkPllRecalibrate;

    // PLL status comes from the analog domain, so two flops first
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            statusMeta <= STATUS_RESET;
            statusSync <= STATUS_RESET;
        end else begin
            statusMeta <= {pllBandHighIn, pllBandLowIn, pllCalibratedIn, pllLockedIn};
            statusSync <= statusMeta;
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Sync buffer power-down
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            firstSyncBufferOff  <= SYNC_OFF_RESET;
            secondSyncBufferOff <= SYNC_OFF_RESET;
        end else if (regWrite && regAddr == SYNC_BUFFER_POWER_DOWN_ADDR) begin
            firstSyncBufferOff  <= regWriteData[FIRST_SYNC_BIT];
            secondSyncBufferOff <= regWriteData[SECOND_SYNC_BIT];
        end
    end

    // Lane recovery reset, active low
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            recoveryReset_n <= RECOVERY_RST_RESET;
        end else if (regWrite && regAddr == RECOVERY_LOGIC_RESET_ADDR) begin
            recoveryReset_n <= regWriteData[RECOVERY_RST_BIT];
        end
    end

    // Recovery mode; choosing a mode by lane rate is software's job
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            halfRateRecoveryOn   <= HALF_RATE_RESET;
            recoveryModeReserved <= MODE_RSVD_RESET;
            inputOversampleOn    <= OVERSAMPLE_RESET;
        end else if (regWrite && regAddr == RECOVERY_OPERATING_MODE_ADDR) begin
            halfRateRecoveryOn   <= regWriteData[HALF_RATE_BIT];
            recoveryModeReserved <= regWriteData[MODE_RSVD_LSB +: 3];
            inputOversampleOn    <= regWriteData[OVERSAMPLE_BIT];
        end
    end

    // Link configuration byte
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            linkConfigByte <= LINK_CONFIG_RESET;
        end else if (regWrite && regAddr == LINK_CONFIG_BYTE_ADDR) begin
            linkConfigByte <= regWriteData;
        end
    end

    // Equalizer power mode and its trim bits
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            equalizerPowerSelect <= EQ_SELECT_RESET;
            equalizerReserved    <= EQ_RSVD_RESET;
        end else if (regWrite && regAddr == EQUALIZER_BIAS_ADDR) begin
            equalizerPowerSelect <= regWriteData[EQ_SELECT_LSB +: 2];
            equalizerReserved    <= regWriteData[EQ_SELECT_LSB-1:0];
        end
    end

    // PLL enable and recalibrate bits
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            linkPllOn          <= PLL_ON_RESET;
            linkPllRecalibrate <= PLL_RECAL_RESET;
        end else if (regWrite && regAddr == LINK_PLL_ENABLE_CONTROL_ADDR) begin
            linkPllOn          <= regWriteData[PLL_ON_BIT];
            linkPllRecalibrate <= regWriteData[PLL_RECAL_BIT];
        end
    end

    // One-cycle calibration start: recal rising edge or enable rising edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            linkPllCalStart <= CAL_START_RESET;
        end else begin
            linkPllCalStart <= regWrite && regAddr == LINK_PLL_ENABLE_CONTROL_ADDR &&
                               ((regWriteData[PLL_RECAL_BIT] && !linkPllRecalibrate) ||
                                (regWriteData[PLL_ON_BIT] && !linkPllOn));
        end
    end

    // Loop-filter and charge-pump trims; optimum values written by software
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            linkPllFilterTrimA <= FILTER_A_RESET;
            linkPllFilterTrimB <= FILTER_B_RESET;
            linkPllFilterTrimC <= FILTER_C_RESET;
            linkPllPumpTrim    <= PUMP_RESET;
        end else if (regWrite) begin
            if (regAddr == LINK_PLL_FILTER_TRIM_A_ADDR) linkPllFilterTrimA <= regWriteData;
            if (regAddr == LINK_PLL_FILTER_TRIM_B_ADDR) linkPllFilterTrimB <= regWriteData;
            if (regAddr == LINK_PLL_FILTER_TRIM_C_ADDR) linkPllFilterTrimC <= regWriteData;
            if (regAddr == LINK_PLL_PUMP_TRIM_ADDR) linkPllPumpTrim <= regWriteData;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] next_regReadData;

    // Unused bits read zero, the mode and equalizer reserved fields read back; unmapped addresses read zero
    always_comb begin
        next_regReadData = READ_IDLE;
        unique case (regAddr)
            SYNC_BUFFER_POWER_DOWN_ADDR: begin
                next_regReadData[FIRST_SYNC_BIT]  = firstSyncBufferOff;
                next_regReadData[SECOND_SYNC_BIT] = secondSyncBufferOff;
            end
            RECOVERY_LOGIC_RESET_ADDR: begin
                next_regReadData[RECOVERY_RST_BIT] = recoveryReset_n;
            end
            RECOVERY_OPERATING_MODE_ADDR: begin
                next_regReadData[HALF_RATE_BIT]         = halfRateRecoveryOn;
                next_regReadData[MODE_RSVD_LSB +: 3]    = recoveryModeReserved;
                next_regReadData[OVERSAMPLE_BIT]        = inputOversampleOn;
            end
            LINK_CONFIG_BYTE_ADDR:       next_regReadData = linkConfigByte;
            EQUALIZER_BIAS_ADDR:         next_regReadData = {equalizerPowerSelect, equalizerReserved};
            LINK_PLL_ENABLE_CONTROL_ADDR: begin
                next_regReadData[PLL_RECAL_BIT] = linkPllRecalibrate;
                next_regReadData[PLL_ON_BIT]    = linkPllOn;
            end
            LINK_PLL_STATUS_ADDR: begin
                next_regReadData[BAND_HIGH_BIT]  = statusSync[3];
                next_regReadData[BAND_LOW_BIT]   = statusSync[2];
                next_regReadData[CALIBRATED_BIT] = statusSync[1];
                next_regReadData[LOCKED_BIT]     = statusSync[0];
            end
            LINK_PLL_FILTER_TRIM_A_ADDR: next_regReadData = linkPllFilterTrimA;
            LINK_PLL_FILTER_TRIM_B_ADDR: next_regReadData = linkPllFilterTrimB;
            LINK_PLL_FILTER_TRIM_C_ADDR: next_regReadData = linkPllFilterTrimC;
            LINK_PLL_PUMP_TRIM_ADDR:     next_regReadData = linkPllPumpTrim;
            default:                     next_regReadData = READ_IDLE;
        endcase
    end

    // Registered read data, held between reads
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            regReadData <= READ_IDLE;
        end else if (regRead) begin
            regReadData <= next_regReadData;
        end
    end

endmodule

// File: sppcr_regs_chk.sv
module sppcr_regs_chk
    import sppcr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWriteData,
    input wire logic [7:0]  regReadData,
    input wire logic        firstSyncBufferOff,
    input wire logic        secondSyncBufferOff,
    input wire logic        recoveryReset_n,
    input wire logic [1:0]  equalizerPowerSelect,
    input wire logic        linkPllOn,
    input wire logic        linkPllCalStart,
    input wire logic [7:0]  linkConfigByte,
    input wire logic [7:0]  linkPllPumpTrim
);
    // -----------------------------------------
    // Port relations
    // -----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Decoded PLL enable write, shared by several checks
    wire wrPll = regWrite && regAddr == LINK_PLL_ENABLE_CONTROL_ADDR;
    property p_sync; regWrite && regAddr == SYNC_BUFFER_POWER_DOWN_ADDR |=>
        {firstSyncBufferOff, secondSyncBufferOff} == $past(regWriteData[1:0]); endproperty
    a_sync: assert property (p_sync) else $error("sync buffer bits wrong");
    property p_rrst; regWrite && regAddr == RECOVERY_LOGIC_RESET_ADDR |=> recoveryReset_n == $past(regWriteData[0]);
    endproperty
    a_rrst: assert property (p_rrst) else $error("recovery reset bit wrong");
    property p_eq; regWrite && regAddr == EQUALIZER_BIAS_ADDR |=> equalizerPowerSelect == $past(regWriteData[7:6]);
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer select wrong");
    property p_on; wrPll |=> linkPllOn == $past(regWriteData[0]); endproperty
    a_on: assert property (p_on) else $error("pll enable wrong");
    // Back-to-back rising writes may give adjacent pulses, so only a lone pulse must drop
    property p_calpulse; linkPllCalStart && !wrPll |=> !linkPllCalStart; endproperty
    a_calpulse: assert property (p_calpulse) else $error("cal start longer than one cycle");
    property p_calrise; wrPll && regWriteData[0] && !linkPllOn |=> linkPllCalStart; endproperty
    a_calrise: assert property (p_calrise) else $error("enable did not start calibration");
    property p_calcause; linkPllCalStart |-> $past(wrPll) && ($past(regWriteData[2]) || $past(regWriteData[0]));
    endproperty
    a_calcause: assert property (p_calcause) else $error("cal start without cause");
    property p_cfghold; !regWrite |=> $stable(linkConfigByte); endproperty
    a_cfghold: assert property (p_cfghold) else $error("config byte changed alone");
    property p_pumphold; !$stable(linkPllPumpTrim) |-> $past(regWrite) && $past(regAddr) == LINK_PLL_PUMP_TRIM_ADDR;
    endproperty
    a_pumphold: assert property (p_pumphold) else $error("pump trim changed alone");
    property p_rsvd; regRead && regAddr == LINK_PLL_STATUS_ADDR |=> regReadData[7:6] == 2'h0 && regReadData[2:1] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
    // Main scenarios reached
    c_cal: cover property (linkPllCalStart);
    c_cfg: cover property (regWrite && regAddr == LINK_CONFIG_BYTE_ADDR && regWriteData == 8'hFF);
    c_rw: cover property (regWrite && regRead);
endmodule

bind sppcr_regs sppcr_regs_chk chk_u (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
    .firstSyncBufferOff(firstSyncBufferOff), .secondSyncBufferOff(secondSyncBufferOff),
    .recoveryReset_n(recoveryReset_n), .equalizerPowerSelect(equalizerPowerSelect), .linkPllOn(linkPllOn),
    .linkPllCalStart(linkPllCalStart), .linkConfigByte(linkConfigByte), .linkPllPumpTrim(linkPllPumpTrim));

// File: tb_sppcr_regs.sv
module tb_sppcr_regs
    import sppcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset_n, regWrite, regRead, readSeen, lk, cv, bh, bl, pOn, cStart;
    logic [11:0] regAddr;
    logic [7:0] regWriteData, regReadData, cfg, tA, tB, tC, tP, s, d [11];
    logic [2:0] mRsv;
    logic [1:0] eqSel;
    logic [5:0] eqRsv;
    logic s1, s2, rRst, hRate, oSmp;
    int numErrors, checkCount, cycles;
    logic [7:0] expQ [$];
    localparam logic [11:0] ADDRS [11] = '{SYNC_BUFFER_POWER_DOWN_ADDR, RECOVERY_LOGIC_RESET_ADDR,
        RECOVERY_OPERATING_MODE_ADDR, LINK_CONFIG_BYTE_ADDR, EQUALIZER_BIAS_ADDR, LINK_PLL_ENABLE_CONTROL_ADDR,
        LINK_PLL_STATUS_ADDR, LINK_PLL_FILTER_TRIM_A_ADDR, LINK_PLL_FILTER_TRIM_B_ADDR,
        LINK_PLL_FILTER_TRIM_C_ADDR, LINK_PLL_PUMP_TRIM_ADDR};
    localparam logic [7:0] RSTV [11] = '{8'h00, 8'h01, 8'h28, 8'h00, 8'h62, 8'h00, 8'h00, 8'h77, 8'h87, 8'h08, 8'h3F};
    localparam logic [7:0] MASK [11] = '{8'h03, 8'h01, 8'h3E, 8'hFF, 8'hFF, 8'h05, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    // Enable writes and the pulse they should give, bit 0 then bit 2 rising
    localparam logic [7:0] PLLW [6] = '{8'h00, 8'h01, 8'h05, 8'h05, 8'h01, 8'h04};
    localparam logic PLLP [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    sppcr_regs dut_u (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWriteData(regWriteData), .pllLockedIn(lk), .pllCalibratedIn(cv),
        .pllBandHighIn(bh), .pllBandLowIn(bl), .regReadData(regReadData), .firstSyncBufferOff(s1),
        .secondSyncBufferOff(s2), .recoveryReset_n(rRst), .halfRateRecoveryOn(hRate), .inputOversampleOn(oSmp),
        .recoveryModeReserved(mRsv), .linkConfigByte(cfg), .equalizerPowerSelect(eqSel),
        .equalizerReserved(eqRsv), .linkPllOn(pOn), .linkPllCalStart(cStart), .linkPllFilterTrimA(tA),
        .linkPllFilterTrimB(tB), .linkPllFilterTrimC(tC), .linkPllPumpTrim(tP));

    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (numErrors == 0 && checkCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One cycle per call, so back-to-back requests keep a strobe asserted with no idle cycle between them
    task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [7:0] dat);
        regWrite = w;
        regRead = r;
        regAddr = a;
        regWriteData = dat;
        @(posedge core_clk);
        #2;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        op(1'b0, 1'b1, a, 8'($urandom));
    endtask
    // Reset, then every register must show its reset value
    task automatic rstAll();
        reset_n = 1'b0;
        repeat (5) op(1'b0, 1'b0, 12'h0000, 8'h00);
        reset_n = 1'b1;
        foreach (ADDRS[i]) rd(ADDRS[i], RSTV[i]);
    endtask

    // ------------------------------------------
    // Clock, monitor and timeout
    // ------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Read data is compared half a cycle after the edge that answers
    always @(posedge core_clk) readSeen <= regRead;
    always @(negedge core_clk) begin
        if (readSeen === 1'b1 && expQ.size() > 0) check(regReadData, expQ.pop_front());
    end
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        {lk, cv, bh, bl} = 4'h0;
        void'($urandom(32'h1f3e));
        rstAll();
        foreach (d[i]) d[i] = 8'($urandom);
        // mode reserved field kept at default
        d[2][4:2] = MODE_RSVD_RESET;
        // defined equalizer codes only, low bits kept
        d[4] = {1'b0, d[4][6], EQ_RSVD_RESET};
        foreach (ADDRS[i]) op(1'b1, 1'b0, ADDRS[i], d[i]);
        foreach (ADDRS[i]) rd(ADDRS[i], d[i] & MASK[i]);
        check({s1, s2, rRst, hRate, oSmp, mRsv}, {d[0][1:0], d[1][0], d[2][5], d[2][1], d[2][4:2]});
        check({eqSel, eqRsv}, d[4]);
        check(tA, d[7]);
        check(tB, d[8]);
        check(tC, d[9]);
        check(tP, d[10]);
        // read in the write cycle sees the old byte
        expQ.push_back(d[3]);
        op(1'b1, 1'b1, LINK_CONFIG_BYTE_ADDR, 8'hFF);
        check(cfg, 8'hFF);
        rd(12'h0282, 8'h00);
        op(1'b1, 1'b0, 12'h0282, 8'($urandom));
        rd(12'h0000, 8'h00);
        // calibration pulse on rising bits only
        foreach (PLLW[i]) begin
            op(1'b1, 1'b0, LINK_PLL_ENABLE_CONTROL_ADDR, PLLW[i]);
            check({6'h00, pOn, cStart}, {6'h00, PLLW[i][0], PLLP[i]});
        end
        op(1'b1, 1'b0, LINK_PLL_FILTER_TRIM_A_ADDR, 8'h62);
        op(1'b1, 1'b0, LINK_PLL_FILTER_TRIM_B_ADDR, 8'hC9);
        op(1'b1, 1'b0, LINK_PLL_FILTER_TRIM_C_ADDR, 8'h0E);
        op(1'b1, 1'b0, LINK_PLL_PUMP_TRIM_ADDR, 8'h12);
        check(tA, 8'h62);
        check(tB, 8'hC9);
        check(tC, 8'h0E);
        check(tP, 8'h12);
        // half-rate then oversampled lane setup, reserved field kept
        op(1'b1, 1'b0, RECOVERY_OPERATING_MODE_ADDR, {2'h0, 1'b1, MODE_RSVD_RESET, 2'h0});
        check({6'h00, hRate, oSmp}, 8'h02);
        op(1'b1, 1'b0, RECOVERY_OPERATING_MODE_ADDR, {2'h0, 1'b0, MODE_RSVD_RESET, 1'b1, 1'b0});
        check({6'h00, hRate, oSmp}, 8'h01);
        rd(RECOVERY_OPERATING_MODE_ADDR, 8'h0A);
        repeat (8) begin
            s = 8'($urandom);
            {bh, bl, cv, lk} = s[3:0];
            repeat (3) op(1'b0, 1'b0, 12'h0000, 8'h00);
            rd(LINK_PLL_STATUS_ADDR, {2'h0, s[3:1], 2'h0, s[0]});
        end
        // Status pins idle again, so reset reads see a quiet PLL
        {lk, cv, bh, bl} = 4'h0;
        rstAll();
        repeat (3) op(1'b0, 1'b0, 12'h0000, 8'h00);
        check(8'(expQ.size()), 8'h00);
        summarize();
    end
endmodule
